/* File: shared/hrs_flag_if.sv */
/*
 Carrier for the sticky flag bank: set events and clear requests in,
 flag levels out.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface hrs_flag_if #(
   parameter int N = 5
);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] flags;

   modport owner (input set, input clr, output flags);
   modport user (output set, output clr, input flags);
endinterface

/* File: shared/hrs_pkg.sv */
/*
 Constants for the result and status register section: byte offsets,
 field positions, reset values and widths.
 Assumes a byte-wide register port with 8-bit offsets.
*/
package hrs_pkg;

   // ----------------------------------------
   // port widths
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int AXIS_W = 16;
   localparam int ANGLE_W = 13;
   localparam int ANGLE_FRAC_W = 4;
   localparam int COUNT_W = 3;
   localparam int FAULT_N = 4;
   localparam int FLAG_N = 5;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_Y_HIGH = 8'h14;
   localparam logic [7:0] OFF_Y_LOW = 8'h15;
   localparam logic [7:0] OFF_Z_HIGH = 8'h16;
   localparam logic [7:0] OFF_Z_LOW = 8'h17;
   localparam logic [7:0] OFF_CONV_STATE = 8'h18;
   localparam logic [7:0] OFF_ANGLE_HIGH = 8'h19;
   localparam logic [7:0] OFF_ANGLE_LOW = 8'h1a;
   localparam logic [7:0] OFF_MAGNITUDE = 8'h1b;
   localparam logic [7:0] OFF_HEALTH = 8'h1c;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CS_COUNT_LSB = 5;
   localparam int CS_POR = 4;
   localparam int CS_DIAG = 1;
   localparam int CS_READY = 0;
   localparam int DH_IRQ_RB = 4;
   localparam int FLT_OSC = 3;
   localparam int FLT_IRQ = 2;
   localparam int FLT_MEM = 1;
   localparam int FLT_SUPPLY = 0;
   localparam int FLAG_POR = 4;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RESULT_RST = 8'h00;
   localparam logic [7:0] CONV_STATE_RST = 8'h10;
   localparam logic [7:0] HEALTH_RST = 8'h10;
   localparam logic [4:0] FLAGS_RST = 5'h10;
   localparam logic IRQ_RB_RST = 1'b1;

endpackage

/* File: testbench/hrs_host_model.sv */
/*
 Host side model: byte register reads and writes through strobes.
 Assumes each request is launched just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module hrs_host_model
   import hrs_pkg::*;
(
   input wire logic sys_clk,
   output logic [ADDR_W-1:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid
);
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end

   // one read; a released bus shows the inverse of the last address
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      ok = (reg_rvalid === 1'b1);
      d = reg_rdata;
   endtask

   // one write; no answer comes back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule

/* File: testbench/tb_top.sv */
/*
 Self-checking bench for the result and status register section.
 Assumes the host model drives the register port; the bench plays the
 conversion engine, the fault checkers and the interrupt pin.
*/
`timescale 1ns/1ps
module tb_top;
   import hrs_pkg::*;
   logic sys_clk, rst_n, set_valid, data_complete, irq_pin_level, reg_rd, reg_wr;
   logic reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, mag;
   logic [15:0] y, z;
   logic [12:0] ang;
   logic [3:0] fault_event, flt;
   logic [2:0] cnt;
   logic por, rdy, pin;
   int n_errors, comparisons;

   // ----------------------------------------
   // instances and clock
   // ----------------------------------------
   hrs_result_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .set_valid(set_valid), .y_axis_value(y),
      .z_axis_value(z), .angle_value(ang), .magnitude_value(mag),
      .data_complete(data_complete), .fault_event(fault_event),
      .irq_pin_level(irq_pin_level));
   hrs_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // free running 50 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] cs_exp();
      return {cnt, por, 2'b00, |flt, rdy};
   endfunction

   function automatic logic [7:0] hl_exp();
      return {3'b000, pin, flt};
   endfunction

   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // read one offset and compare; a missing answer ends the run
   task automatic rdc(logic [7:0] a, logic [7:0] e);
      logic [7:0] d;
      logic ok;
      u_host.rd(a, d, ok);
      chk("read answer", {7'h00, ok}, 8'h01);
      if (ok !== 1'b1) begin
         results();
      end else begin
         chk($sformatf("offset %h", a), d, e);
      end
   endtask

   // one data set from the conversion engine
   task automatic push(logic [15:0] yv, logic [15:0] zv, logic [12:0] av, logic [7:0] mv);
      @(posedge sys_clk);
      #1;
      {y, z, ang, mag} = {yv, zv, av, mv};
      set_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      set_valid = 1'b0;
      cnt = cnt + 3'd1;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      for (int a = 8'h14; a <= 8'h1b; a++) begin
         rdc(8'(a), (a == 8'h18) ? 8'h10 : 8'h00);
      end
      rdc(8'h1c, 8'h10);
      rdc(8'h1d, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_data();
      logic [7:0] d;
      logic ok;
      push(16'ha5c3, 16'h3c5a, 13'h1678, 8'h9e);
      rdc(8'h14, 8'ha5);
      rdc(8'h15, 8'hc3);
      rdc(8'h16, 8'h3c);
      rdc(8'h17, 8'h5a);
      rdc(8'h19, 8'h16);
      rdc(8'h1a, 8'h78);
      rdc(8'h1b, 8'h9e);
      rdc(8'h1b, 8'h9e);
      u_host.rd(8'h1a, d, ok);
      chk("angle sixteenths", {4'h0, d[3:0]}, 8'h08);
      u_host.wr(8'h14, 8'hff);
      rdc(8'h14, 8'ha5);
      push(16'h0102, 16'h0304, 13'h0005, 8'h06);
      rdc(8'h17, 8'h04);
      push(16'h0708, 16'h090a, 13'h000b, 8'h0c);
      rdc(8'h1b, 8'h0c);
      $display("test data set done");
   endtask

   task automatic t_count();
      for (int i = 0; i < 8; i++) begin
         push(16'(i * 16'h1111), 16'hffff, 13'(i), 8'(i));
         rdc(8'h18, cs_exp());
      end
      u_host.wr(8'h18, 8'hef);
      rdc(8'h18, cs_exp());
      u_host.wr(8'h18, 8'h10);
      por = 1'b0;
      rdc(8'h18, cs_exp());
      $display("test count done");
   endtask

   task automatic t_ready();
      @(posedge sys_clk);
      #1;
      data_complete = 1'b1;
      rdy = 1'b1;
      rdc(8'h18, cs_exp());
      data_complete = 1'b0;
      rdy = 1'b0;
      rdc(8'h18, cs_exp());
      $display("test ready done");
   endtask

   task automatic t_fault();
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         #1;
         fault_event = 4'h1 << i;
         @(posedge sys_clk);
         #1;
         fault_event = 4'h0;
         flt[i] = 1'b1;
         rdc(8'h18, cs_exp());
         rdc(8'h1c, hl_exp());
         u_host.wr(8'h1c, 8'h00);
         rdc(8'h1c, hl_exp());
         u_host.wr(8'h1c, 8'h01 << i);
         flt[i] = 1'b0;
         rdc(8'h1c, hl_exp());
         rdc(8'h18, cs_exp());
      end
      $display("test faults done");
   endtask

   task automatic t_pin();
      irq_pin_level = 1'b0;
      pin = 1'b0;
      repeat (3) @(posedge sys_clk);
      rdc(8'h1c, hl_exp());
      irq_pin_level = 1'b1;
      pin = 1'b1;
      repeat (3) @(posedge sys_clk);
      rdc(8'h1c, hl_exp());
      $display("test pin done");
   endtask

   task automatic t_reset2();
      irq_pin_level = 1'b0;
      pin = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      {cnt, por, flt, rdy} = {3'd0, 1'b1, 4'h0, 1'b0};
      repeat (4) @(posedge sys_clk);
      rdc(8'h18, 8'h10);
      rdc(8'h1c, 8'h00);
      rdc(8'h14, 8'h00);
      $display("test second reset done");
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst_n, set_valid, data_complete, fault_event} = {1'b0, 1'b0, 1'b0, 4'h0};
      {y, z, ang, mag, irq_pin_level, pin} = '0;
      irq_pin_level = 1'b1;
      pin = 1'b1;
      {cnt, por, flt, rdy} = {3'd0, 1'b1, 4'h0, 1'b0};
      n_errors = 0;
      comparisons = 0;
      repeat (8) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_data();
      t_count();
      t_ready();
      t_fault();
      t_pin();
      t_reset2();
      results();
   end
endmodule

/* File: verilog/hrs_flags.sv */
/*
 Bank of sticky write-one-to-clear flags with per-bit reset values.
 Assumes set and clear arrive as one-cycle levels on sys_clk.
*/
`timescale 1ns/1ps
module hrs_flags
   import hrs_pkg::*;
#(
   parameter int N = 5,
   parameter logic [N-1:0] RST_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   hrs_flag_if.owner fi
);

   // ----------------------------------------
   // one sticky flag per bit
   // ----------------------------------------
   for (genvar i = 0; i < N; i++) begin : g_bit
      logic q_reg;
      logic q_next;

      // set wins over a clear in the same cycle
      always_comb begin
         q_next = fi.set[i] | (q_reg & ~fi.clr[i]);
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            q_reg <= RST_VAL[i];
         end else begin
            q_reg <= q_next;
         end
      end

      assign fi.flags[i] = q_reg;

      a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
         fi.set[i] |=> fi.flags[i])
         else $error("flag lost a set event");

      a_flag_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
         (!fi.set[i] && !fi.clr[i]) |=> fi.flags[i] == $past(fi.flags[i]))
         else $error("flag changed without cause");
   end

endmodule

/* File: verilog/hrs_result_regs.sv */
/*
 Result and status register section of a three-axis field sensor:
 axis results, conversion state, angle, magnitude and device health.
 Assumes the serial bus layer presents a byte register port on sys_clk,
 and the conversion engine and checkers drive their inputs on sys_clk.
 The interrupt pin readback arrives from a pin and is synchronised.
*/
// Behaviour
// - y result readable at 14h and 15h
// - z result readable at 16h and 17h
// - three-bit wrapping count of data sets
// - power-on flag set at reset, write-one clears
// - diagnostic bit is OR of fault flags
// - ready bit follows data-complete level
// - 13-bit angle split over 19h and 1ah
// - low four angle bits are sixteenths
// - eight-bit magnitude readable at 1bh
// - health bit 4 shows interrupt pin level
// - readback reset follows pin after release
// - conversion state resets to 10h
// - four fault flags, write-one clears each
`timescale 1ns/1ps
module hrs_result_regs
   import hrs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic set_valid,
   input wire logic [AXIS_W-1:0] y_axis_value,
   input wire logic [AXIS_W-1:0] z_axis_value,
   input wire logic [ANGLE_W-1:0] angle_value,
   input wire logic [DATA_W-1:0] magnitude_value,
   input wire logic data_complete,
   input wire logic [FAULT_N-1:0] fault_event,
   input wire logic irq_pin_level
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [AXIS_W-1:0] y_reg;
   logic [AXIS_W-1:0] y_next;
   logic [AXIS_W-1:0] z_reg;
   logic [AXIS_W-1:0] z_next;
   logic [ANGLE_W-1:0] angle_reg;
   logic [ANGLE_W-1:0] angle_next;
   logic [DATA_W-1:0] mag_reg;
   logic [DATA_W-1:0] mag_next;
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic ready_reg;
   logic ready_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [FLAG_N-1:0] clr_req;
   logic irq_rb;
   logic diag;
   logic por;
   logic [FAULT_N-1:0] faults;
   logic [DATA_W-1:0] conv_state;
   logic [DATA_W-1:0] health;
   logic [2*DATA_W-1:0] angle_word;

   hrs_flag_if #(.N(FLAG_N)) flag_bus ();

   // ----------------------------------------
   // sticky flags and pin readback
   // ----------------------------------------

   // power-on flag has no set source; it comes back only with reset
   assign flag_bus.set = {1'b0, fault_event};
   assign flag_bus.clr = clr_req;

   hrs_flags #(
      .N(FLAG_N),
      .RST_VAL(FLAGS_RST)
   ) u_flags (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .fi(flag_bus.owner)
   );

   // pin level reads as high during reset, then tracks the pin
   hrs_sync #(
      .RST_VAL(IRQ_RB_RST)
   ) u_irq_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(irq_pin_level),
      .sync_out(irq_rb)
   );

   assign por = flag_bus.flags[FLAG_POR];
   assign faults = flag_bus.flags[FAULT_N-1:0];
   assign diag = |faults;

   // ----------------------------------------
   // write decode: only write-one-to-clear bits respond
   // ----------------------------------------
   always_comb begin
      clr_req = '0;
      if (reg_wr && reg_addr == OFF_CONV_STATE) begin
         clr_req[FLAG_POR] = reg_wdata[CS_POR];
      end
      if (reg_wr && reg_addr == OFF_HEALTH) begin
         clr_req[FLT_OSC] = reg_wdata[FLT_OSC];
         clr_req[FLT_IRQ] = reg_wdata[FLT_IRQ];
         clr_req[FLT_MEM] = reg_wdata[FLT_MEM];
         clr_req[FLT_SUPPLY] = reg_wdata[FLT_SUPPLY];
      end
   end

   // ----------------------------------------
   // conversion results
   // ----------------------------------------

   // a new data set loads all results at once and bumps the count
   always_comb begin
      y_next = y_reg;
      z_next = z_reg;
      angle_next = angle_reg;
      mag_next = mag_reg;
      count_next = count_reg;
      ready_next = data_complete;
      if (set_valid) begin
         y_next = y_axis_value;
         z_next = z_axis_value;
         angle_next = angle_value;
         mag_next = magnitude_value;
         count_next = count_reg + 3'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         y_reg <= {RESULT_RST, RESULT_RST};
         z_reg <= {RESULT_RST, RESULT_RST};
         angle_reg <= '0;
         mag_reg <= RESULT_RST;
         count_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         y_reg <= y_next;
         z_reg <= z_next;
         angle_reg <= angle_next;
         mag_reg <= mag_next;
         count_reg <= count_next;
         ready_reg <= ready_next;
      end
   end

   // ----------------------------------------
   // read views
   // ----------------------------------------

   // reserved bits read as zero
   assign conv_state = {count_reg, por, 2'b00, diag, ready_reg};
   assign health = {3'b000, irq_rb, faults};
   assign angle_word = {3'b000, angle_reg};

   // ----------------------------------------
   // read port: value one cycle after the strobe
   // ----------------------------------------
   always_comb begin
      rvalid_next = reg_rd;
      rdata_next = rdata_reg;
      if (reg_rd) begin
         unique case (reg_addr)
            OFF_Y_HIGH: rdata_next = y_reg[15:8];
            OFF_Y_LOW: rdata_next = y_reg[7:0];
            OFF_Z_HIGH: rdata_next = z_reg[15:8];
            OFF_Z_LOW: rdata_next = z_reg[7:0];
            OFF_CONV_STATE: rdata_next = conv_state;
            OFF_ANGLE_HIGH: rdata_next = angle_word[15:8];
            OFF_ANGLE_LOW: rdata_next = angle_word[7:0];
            OFF_MAGNITUDE: rdata_next = mag_reg;
            OFF_HEALTH: rdata_next = health;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // reading has no side effect on any flag or result
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------

   a_count_wraps: assert property (@(posedge sys_clk) disable iff (!rst_n)
      set_valid |=> count_reg == 3'($past(count_reg) + 3'h1))
      else $error("set count did not advance by one");

   a_count_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !set_valid |=> $stable(count_reg))
      else $error("set count moved without a data set");

   a_y_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_Y_HIGH) |=>
         reg_rvalid && reg_rdata == $past(y_reg[15:8]))
      else $error("y high byte read wrong");

   a_z_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (set_valid ##1 !set_valid ##1 (reg_rd && reg_addr == OFF_Z_LOW)) |=>
         reg_rdata == $past(z_axis_value[7:0], 3))
      else $error("z low byte not from last data set");

   a_por_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFF_CONV_STATE && reg_wdata[CS_POR]) |=> !por)
      else $error("power-on flag not cleared by write one");

   a_por_zero_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFF_CONV_STATE && !reg_wdata[CS_POR]) |=> $stable(por))
      else $error("power-on flag changed by write zero");

   a_diag_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fault_event != 4'h0 ##1 !reg_wr ##1 (reg_rd && reg_addr == OFF_CONV_STATE))
         |=> reg_rdata[CS_DIAG])
      else $error("diagnostic bit missed a fault");

   a_ready_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (data_complete ##1 (reg_rd && reg_addr == OFF_CONV_STATE)) |=>
         reg_rdata[CS_READY])
      else $error("ready bit did not follow data complete");

   a_angle_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_ANGLE_HIGH) |=>
         reg_rdata == {3'b000, $past(angle_reg[12:8])})
      else $error("angle high byte read wrong");

   a_mag_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (set_valid ##1 !set_valid ##1 (reg_rd && reg_addr == OFF_MAGNITUDE)) |=>
         reg_rdata == $past(magnitude_value, 3))
      else $error("magnitude not from last data set");

   a_irq_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
      irq_pin_level [*3] |-> irq_rb == irq_pin_level)
      else $error("pin readback not tracking pin");

   a_read_clean: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && !reg_wr && fault_event == 4'h0 && !set_valid) |=>
         $stable(flag_bus.flags) && $stable(y_reg) && $stable(angle_reg))
      else $error("read changed device state");

   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && (reg_addr < OFF_Y_HIGH || reg_addr > OFF_HEALTH)) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_irq_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!irq_pin_level) [*3] |-> !irq_rb)
      else $error("pin readback not low for a low pin");

   a_ready_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!data_complete ##1 (reg_rd && reg_addr == OFF_CONV_STATE)) |=>
         !reg_rdata[CS_READY])
      else $error("ready bit set while data incomplete");

   a_rvalid_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !reg_rd |=> !reg_rvalid)
      else $error("read answer without a read");

   a_health_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_HEALTH) |=>
         reg_rdata[7:5] == 3'h0 && reg_rdata[FAULT_N-1:0] == $past(faults))
      else $error("health byte read wrong");

   a_fault_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == OFF_HEALTH && reg_wdata[FLT_OSC] && !fault_event[FLT_OSC])
         |=> !faults[FLT_OSC])
      else $error("oscillator fault not cleared by write one");

   a_y_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_Y_LOW) |=> reg_rdata == $past(y_reg[7:0]))
      else $error("y low byte read wrong");

   a_angle_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_ANGLE_LOW) |=> reg_rdata == $past(angle_reg[7:0]))
      else $error("angle low byte read wrong");

   a_conv_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == OFF_CONV_STATE) |=> reg_rdata[3:2] == 2'h0)
      else $error("conversion state reserved bits not zero");

endmodule

/* File: verilog/hrs_sync.sv */
/*
 Two flip-flop synchroniser for one level from a pin.
 Assumes the pin is slow against sys_clk.
*/
`timescale 1ns/1ps
module hrs_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);

   logic stage1_reg;
   logic stage1_next;
   logic stage2_reg;
   logic stage2_next;

   // ----------------------------------------
   // two stages, the first read only by the second
   // ----------------------------------------
   always_comb begin
      stage1_next = async_in;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= RST_VAL;
         stage2_reg <= RST_VAL;
      end else begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign sync_out = stage2_reg;

endmodule
